/* File: src/uart_baud_loopback.sv */
// Behaviour
// - Integer divisor programmable from one to 65535.
// - Fraction extends divisor: rational divisor is N plus M over sixteen.
// - Fraction is four bits, bits 3..0; zero means plain integer division.
// - Divisor split into high byte and low byte registers.
// - Modem control bit seven selects prescale of one or four.
// - Bit rate is clock over prescale times sixteen times divisor.
// - Transmitter and receiver share one baud generator.
// - Generator works with input clock up to 80 MHz.
// - Generator clock from crystal oscillator or external clock pin.
// - Low four modem control bits drive looped modem values.
// - Loopback joins transmit output to receive input internally.
// - Loopback feeds CTS, DSR, CD, RI from RTS, DTR, user outputs two, one.
// - Host writes test bytes, receiver returns them in receive holding register.
// - Interrupt output tri-stated during loopback; host polls status.
`timescale 1ns/1ps
`default_nettype none
`include "uart_bg_defines.svh"

module uart_baud_loopback
	import uart_bg_pkg::*;
(
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic [2:0] regAddr,
	input wire logic [7:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	output logic [7:0] regRdata,
	input wire logic rxPin,
	output logic txPin,
	input wire logic ctsPinN,
	input wire logic dsrPinN,
	input wire logic cdPinN,
	input wire logic riPinN,
	output logic rtsPinN,
	output logic dtrPinN,
	output logic userOutOneN,
	output logic userOutTwoN,
	input wire logic intRequest,
	output logic intPinOut,
	output logic intPinOeN
);
	function automatic logic regHit(input reg_addr_t addr, input reg_addr_t idx);
		regHit = (addr == idx);
	endfunction

	// Register file
	byte_t divLow_reg;
	byte_t divHigh_reg;
	byte_t modemCtrl_reg;
	logic [3:0] fraction_reg;
	byte_t rdata_reg;

	wire logic wrDivLow = regWr & regHit(regAddr, `ADDR_DIV_LOW);
	wire logic wrDivHigh = regWr & regHit(regAddr, `ADDR_DIV_HIGH);
	wire logic wrModem = regWr & regHit(regAddr, `ADDR_MODEM_CTRL);
	wire logic wrFraction = regWr & regHit(regAddr, `ADDR_FRACTION);
	wire logic wrData = regWr & regHit(regAddr, `ADDR_DATA);
	wire logic rdData = regRd & regHit(regAddr, `ADDR_DATA);
	wire logic rdLineStat = regRd & regHit(regAddr, `ADDR_LINE_STAT);

	wire logic loopMode = modemCtrl_reg[`MC_LOOP_BIT];
	wire logic dtrCtl = modemCtrl_reg[`MC_DTR_BIT];
	wire logic rtsCtl = modemCtrl_reg[`MC_RTS_BIT];
	wire logic user1Ctl = modemCtrl_reg[`MC_USER1_BIT];
	wire logic user2Ctl = modemCtrl_reg[`MC_USER2_BIT];

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			divLow_reg <= `DIV_LOW_RST;
			divHigh_reg <= `DIV_HIGH_RST;
			modemCtrl_reg <= `MODEM_CTRL_RST;
			fraction_reg <= `FRACTION_RST;
		end else begin
			if (wrDivLow) divLow_reg <= regWdata;
			if (wrDivHigh) divHigh_reg <= regWdata;
			if (wrModem) modemCtrl_reg <= regWdata;
			if (wrFraction) fraction_reg <= regWdata[3:0];
		end
	end

	// Pin input filter: three stages, change accepted when stages two and three agree
	localparam int NPIN = 5;
	wire logic [NPIN-1:0] pinRaw = {riPinN, cdPinN, dsrPinN, ctsPinN, rxPin};
	logic [NPIN-1:0] pinFilt;
	genvar gi;
	generate
		for (gi = 0; gi < NPIN; gi++) begin : g_sync
			logic s1_reg;
			logic s2_reg;
			logic s3_reg;
			logic filt_reg;
			always_ff @(posedge core_clk) begin
				if (sys_rst) begin
					s1_reg <= 1'b1;
					s2_reg <= 1'b1;
					s3_reg <= 1'b1;
					filt_reg <= 1'b1;
				end else begin
					s1_reg <= pinRaw[gi];
					s2_reg <= s1_reg;
					s3_reg <= s2_reg;
					if (s2_reg == s3_reg) filt_reg <= s3_reg;
				end
			end
			assign pinFilt[gi] = filt_reg;
		end
	endgenerate

	// Shared sampling tick for both directions
	logic sampleTick;
	uart_baud_gen u_gen (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.prescaleFour(modemCtrl_reg[`MC_PRESCALE_BIT]),
		.divisor({divHigh_reg, divLow_reg}),
		.fraction(fraction_reg),
		.sampleTick(sampleTick)
	);

	// Transmitter, 8 data bits, no parity, one stop bit
	tx_state_e txState_reg;
	byte_t txHold_reg;
	byte_t txShift_reg;
	logic txHoldFull_reg;
	logic [3:0] txSub_reg;
	logic [2:0] txBit_reg;

	wire logic txTake = sampleTick & (txState_reg == TX_IDLE) & txHoldFull_reg;
	// A write in the cycle of a transfer keeps the holding register full
	wire logic txHoldFull_next = wrData | (txHoldFull_reg & ~txTake);
	wire logic txSubEnd = (txSub_reg == `TICKS_LAST);
	wire logic txLine = (txState_reg == TX_START) ? 1'b0 :
		(txState_reg == TX_DATA) ? txShift_reg[0] : 1'b1;

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			txHold_reg <= 8'h00;
			txHoldFull_reg <= 1'b0;
		end else begin
			if (wrData) txHold_reg <= regWdata;
			txHoldFull_reg <= txHoldFull_next;
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			txState_reg <= TX_IDLE;
			txShift_reg <= 8'h00;
			txSub_reg <= 4'h0;
			txBit_reg <= 3'h0;
		end else if (sampleTick) begin
			txSub_reg <= txSub_reg + 4'h1;
			unique case (txState_reg)
				TX_IDLE: begin
					txSub_reg <= 4'h0;
					if (txHoldFull_reg) begin
						txShift_reg <= txHold_reg;
						txState_reg <= TX_START;
					end
				end
				TX_START: begin
					if (txSubEnd) begin
						txBit_reg <= 3'h0;
						txState_reg <= TX_DATA;
					end
				end
				TX_DATA: begin
					if (txSubEnd) begin
						txShift_reg <= {1'b0, txShift_reg[7:1]};
						txBit_reg <= txBit_reg + 3'h1;
						if (txBit_reg == `BITS_LAST) txState_reg <= TX_STOP;
					end
				end
				TX_STOP: begin
					if (txSubEnd) txState_reg <= TX_IDLE;
				end
			endcase
		end
	end

	// Receive path selection: loopback takes the transmitter line directly
	wire logic rxLine = loopMode ? txLine : pinFilt[0];

	// Receiver, samples mid-bit on the sampling tick
	rx_state_e rxState_reg;
	byte_t rxShift_reg;
	byte_t rxHold_reg;
	logic [3:0] rxSub_reg;
	logic [2:0] rxBit_reg;
	logic rxDone_reg;
	logic rxReady_reg;
	logic overrun_reg;

	// Set wins over the clear by a read in the same cycle
	wire logic rxReady_next = rxDone_reg | (rxReady_reg & ~rdData);
	wire logic overrun_next = (rxDone_reg & rxReady_reg & ~rdData) | (overrun_reg & ~rdLineStat);

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			rxState_reg <= RX_IDLE;
			rxShift_reg <= 8'h00;
			rxSub_reg <= 4'h0;
			rxBit_reg <= 3'h0;
			rxDone_reg <= 1'b0;
		end else begin
			rxDone_reg <= 1'b0;
			if (sampleTick) begin
				rxSub_reg <= rxSub_reg + 4'h1;
				unique case (rxState_reg)
					RX_IDLE: begin
						rxSub_reg <= 4'h0;
						if (!rxLine) rxState_reg <= RX_START;
					end
					RX_START: begin
						// Glitch shorter than half a bit returns to idle
						if (rxSub_reg == `TICKS_HALF) begin
							rxSub_reg <= 4'h0;
							rxBit_reg <= 3'h0;
							rxState_reg <= rxLine ? RX_IDLE : RX_DATA;
						end
					end
					RX_DATA: begin
						if (rxSub_reg == `TICKS_LAST) begin
							rxShift_reg <= {rxLine, rxShift_reg[7:1]};
							rxBit_reg <= rxBit_reg + 3'h1;
							if (rxBit_reg == `BITS_LAST) rxState_reg <= RX_STOP;
						end
					end
					RX_STOP: begin
						// Bad stop bit drops the byte
						if (rxSub_reg == `TICKS_LAST) begin
							rxDone_reg <= rxLine;
							rxState_reg <= RX_IDLE;
						end
					end
				endcase
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			rxHold_reg <= 8'h00;
			rxReady_reg <= 1'b0;
			overrun_reg <= 1'b0;
		end else begin
			if (rxDone_reg) rxHold_reg <= rxShift_reg;
			rxReady_reg <= rxReady_next;
			overrun_reg <= overrun_next;
		end
	end

	// Modem inputs, active high inside; loopback routes control bits back
	wire logic ctsIn = loopMode ? rtsCtl : ~pinFilt[1];
	wire logic dsrIn = loopMode ? dtrCtl : ~pinFilt[2];
	wire logic cdIn = loopMode ? user2Ctl : ~pinFilt[3];
	wire logic riIn = loopMode ? user1Ctl : ~pinFilt[4];

	// Status and read mux
	wire logic txIdle = (txState_reg == TX_IDLE) & ~txHoldFull_reg;
	wire byte_t lineStat = {1'b0, txIdle, ~txHoldFull_reg, 3'h0, overrun_reg, rxReady_reg};
	wire byte_t modemStat = {cdIn, riIn, dsrIn, ctsIn, 4'h0};
	wire byte_t readMux =
		regHit(regAddr, `ADDR_DIV_LOW) ? divLow_reg :
		regHit(regAddr, `ADDR_DIV_HIGH) ? divHigh_reg :
		regHit(regAddr, `ADDR_MODEM_CTRL) ? modemCtrl_reg :
		regHit(regAddr, `ADDR_FRACTION) ? {4'h0, fraction_reg} :
		regHit(regAddr, `ADDR_LINE_STAT) ? lineStat :
		regHit(regAddr, `ADDR_MODEM_STAT) ? modemStat :
		regHit(regAddr, `ADDR_DATA) ? rxHold_reg : 8'h00;

	always_ff @(posedge core_clk) begin
		if (sys_rst) rdata_reg <= 8'h00;
		else rdata_reg <= regRd ? readMux : 8'h00;
	end

	// Output pins registered; loopback parks serial and modem outputs at idle levels and disables the interrupt driver
	logic txPin_reg;
	logic rtsN_reg;
	logic dtrN_reg;
	logic user1N_reg;
	logic user2N_reg;
	logic intOut_reg;
	logic intOeN_reg;

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			txPin_reg <= 1'b1;
			rtsN_reg <= 1'b1;
			dtrN_reg <= 1'b1;
			user1N_reg <= 1'b1;
			user2N_reg <= 1'b1;
			intOut_reg <= 1'b0;
			intOeN_reg <= 1'b0;
		end else begin
			txPin_reg <= loopMode | txLine;
			rtsN_reg <= loopMode | ~rtsCtl;
			dtrN_reg <= loopMode | ~dtrCtl;
			user1N_reg <= loopMode | ~user1Ctl;
			user2N_reg <= loopMode | ~user2Ctl;
			intOut_reg <= intRequest;
			intOeN_reg <= loopMode;
		end
	end

	assign regRdata = rdata_reg;
	assign txPin = txPin_reg;
	assign rtsPinN = rtsN_reg;
	assign dtrPinN = dtrN_reg;
	assign userOutOneN = user1N_reg;
	assign userOutTwoN = user2N_reg;
	assign intPinOut = intOut_reg;
	assign intPinOeN = intOeN_reg;
endmodule // uart_baud_loopback

`default_nettype wire

/* File: src/uart_bg_defines.svh */
`ifndef UART_BG_DEFINES_SVH
`define UART_BG_DEFINES_SVH

// Register indices on the 3-bit register port
`define ADDR_DIV_LOW 3'h0
`define ADDR_DIV_HIGH 3'h1
`define ADDR_MODEM_CTRL 3'h2
`define ADDR_FRACTION 3'h3
`define ADDR_LINE_STAT 3'h4
`define ADDR_MODEM_STAT 3'h5
`define ADDR_DATA 3'h6

// Modem control register fields
`define MC_DTR_BIT 0
`define MC_RTS_BIT 1
`define MC_USER1_BIT 2
`define MC_USER2_BIT 3
`define MC_LOOP_BIT 4
`define MC_PRESCALE_BIT 7

// Line status fields
`define LSR_RX_READY_BIT 0
`define LSR_OVERRUN_BIT 1
`define LSR_THR_EMPTY_BIT 5
`define LSR_TX_IDLE_BIT 6

// Modem status fields
`define MSR_CTS_BIT 4
`define MSR_DSR_BIT 5
`define MSR_RI_BIT 6
`define MSR_CD_BIT 7

// Reset values
`define DIV_LOW_RST 8'h01
`define DIV_HIGH_RST 8'h00
`define MODEM_CTRL_RST 8'h00
`define FRACTION_RST 4'h0

// Timing counts in sampling ticks and input clocks
`define TICKS_LAST 4'hf
`define TICKS_HALF 4'h7
`define BITS_LAST 3'h7
`define PRESCALE4_LAST 2'h3

`endif

/* File: src/uart_bg_pkg.sv */
`default_nettype none
package uart_bg_pkg;
	typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} tx_state_e;
	typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_e;
	typedef logic [7:0] byte_t;
	typedef logic [2:0] reg_addr_t;
endpackage
`default_nettype wire

/* File: src/uart_baud_gen.sv */
`timescale 1ns/1ps
`default_nettype none
`include "uart_bg_defines.svh"

module uart_baud_gen
	import uart_bg_pkg::*;
(
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic prescaleFour,
	input wire logic [15:0] divisor,
	input wire logic [3:0] fraction,
	output logic sampleTick
);
	logic [1:0] preCnt_reg;
	logic [15:0] divCnt_reg;
	logic [3:0] phase_reg;
	logic extraDone_reg;
	logic sampleTick_reg;

	// Divide by one or by four ahead of the divisor
	wire logic preTick = prescaleFour ? (preCnt_reg == `PRESCALE4_LAST) : 1'b1;
	// Divisor zero is treated as one so the generator never stalls
	wire logic [15:0] divLoad = (divisor == 16'h0000) ? 16'h0000 : divisor - 16'h0001;
	// Fraction M stretches M of every 16 sampling periods by one prescaled clock
	wire logic stretch = (phase_reg < fraction);
	wire logic atZero = (divCnt_reg == 16'h0000);
	wire logic fire = preTick & atZero & (~stretch | extraDone_reg);

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			preCnt_reg <= 2'h0;
			divCnt_reg <= 16'h0000;
			phase_reg <= 4'h0;
			extraDone_reg <= 1'b0;
			sampleTick_reg <= 1'b0;
		end else begin
			preCnt_reg <= prescaleFour ? preCnt_reg + 2'h1 : 2'h0;
			sampleTick_reg <= fire;
			if (fire) begin
				divCnt_reg <= divLoad;
				phase_reg <= phase_reg + 4'h1;
				extraDone_reg <= 1'b0;
			end else if (preTick & atZero) begin
				extraDone_reg <= 1'b1;
			end else if (preTick) begin
				divCnt_reg <= divCnt_reg - 16'h0001;
			end
		end
	end

	assign sampleTick = sampleTick_reg;
endmodule // uart_baud_gen

`default_nettype wire

/* File: verif/uart_baud_loopback_props.sv */
`timescale 1ns/1ps
`default_nettype none
module uart_baud_loopback_props
	import uart_bg_pkg::*;
(
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic [2:0] regAddr,
	input wire logic [7:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	input wire logic [7:0] regRdata,
	input wire logic txPin,
	input wire logic rtsPinN,
	input wire logic dtrPinN,
	input wire logic userOutOneN,
	input wire logic userOutTwoN,
	input wire logic intRequest,
	input wire logic intPinOut,
	input wire logic intPinOeN
);
	logic [7:0] modemCtrl_reg;
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			modemCtrl_reg <= 8'h00;
		end else if (regWr && regAddr == 3'h2) begin
			modemCtrl_reg <= regWdata;
		end
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	// Outputs are registered, so a mode counts only after two edges
	sequence loopSettled;
		modemCtrl_reg[4] && $past(modemCtrl_reg[4]);
	endsequence
	sequence normSettled;
		!modemCtrl_reg[4] && !$past(modemCtrl_reg[4]);
	endsequence
	AST_LOOP_TX_IDLE: assert property (loopSettled |-> txPin)
		else $error("serial output not idle in loopback");
	AST_LOOP_MODEM_IDLE: assert property (loopSettled |-> &{rtsPinN, dtrPinN, userOutOneN, userOutTwoN})
		else $error("modem outputs not idle in loopback");
	AST_LOOP_INT_TRI: assert property (loopSettled |-> intPinOeN)
		else $error("interrupt pin driven in loopback");
	AST_NORM_INT_DRV: assert property (normSettled |-> !intPinOeN)
		else $error("interrupt pin released in normal mode");
	AST_NORM_MODEM: assert property (!$past(modemCtrl_reg[4]) |-> {rtsPinN, dtrPinN, userOutTwoN, userOutOneN} == ~{$past(modemCtrl_reg[1]), $past(modemCtrl_reg[0]), $past(modemCtrl_reg[3]), $past(modemCtrl_reg[2])})
		else $error("modem outputs differ from control bits");
	AST_INT_COPY: assert property (!$past(sys_rst) |-> intPinOut == $past(intRequest))
		else $error("interrupt pin does not follow request");
	AST_RD_IDLE: assert property (!$past(regRd) |-> regRdata == 8'h00)
		else $error("read data present without a read");
	AST_FRAC_READ: assert property ($past(regRd && regAddr == 3'h3) |-> regRdata[7:4] == 4'h0)
		else $error("fraction register wider than four bits");
endmodule // uart_baud_loopback_props
bind uart_baud_loopback uart_baud_loopback_props props (.core_clk(core_clk), .sys_rst(sys_rst),
	.regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
	.txPin(txPin), .rtsPinN(rtsPinN), .dtrPinN(dtrPinN), .userOutOneN(userOutOneN),
	.userOutTwoN(userOutTwoN), .intRequest(intRequest), .intPinOut(intPinOut),
	.intPinOeN(intPinOeN));
`default_nettype wire

/* File: verif/uart_line_model.sv */
`timescale 1ns/1ps
`default_nettype none
module uart_line_model
	import uart_bg_pkg::*;
(
	input wire logic core_clk,
	input wire logic txPin,
	input wire logic [3:0] modemN,
	input var int bitClks,
	output logic rxPin,
	output logic ctsPinN,
	output logic dsrPinN,
	output logic cdPinN,
	output logic riPinN,
	output logic rxDone,
	output byte_t rxByte
);
	assign {cdPinN, riPinN, dsrPinN, ctsPinN} = modemN;
	initial begin
		rxPin = 1'b1;
		rxDone = 1'b0;
		rxByte = 8'h00;
	end
	// Mid-bit sampling; a wrong bit length drifts off centre within a frame
	always begin
		byte_t b;
		@(negedge txPin);
		repeat (bitClks / 2) @(posedge core_clk);
		for (int i = 0; i < 8; i++) begin
			repeat (bitClks) @(posedge core_clk);
			b[i] = txPin;
		end
		repeat (bitClks) @(posedge core_clk);
		rxByte <= txPin ? b : 8'hxx;
		rxDone <= 1'b1;
		@(posedge core_clk);
		rxDone <= 1'b0;
	end
	task automatic send(input byte_t b);
		for (int i = 0; i < 10; i++) begin
			@(posedge core_clk);
			rxPin <= (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : b[i - 1];
			repeat (bitClks - 1) @(posedge core_clk);
		end
	endtask
endmodule // uart_line_model
`default_nettype wire

/* File: verif/uart_baud_loopback_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module uart_baud_loopback_bench
	import uart_bg_pkg::*;
();
	logic core_clk, sys_rst = 1'b1, regWr = 1'b0, regRd = 1'b0, intRequest = 1'b0;
	logic rxPin, txPin, ctsPinN, dsrPinN, cdPinN, riPinN, rtsPinN, dtrPinN;
	logic userOutOneN, userOutTwoN, intPinOut, intPinOeN, rxDone, chk = 1'b0, chkD = 1'b0;
	reg_addr_t regAddr = 3'h0;
	byte_t regWdata = 8'h00, regRdata, rxByte, lf = 8'h47, regQ[$], serQ[$];
	logic [3:0] modemN = 4'hf;
	int bitClks = 16, mismatches = 0, samplesChecked = 0, cyc = 0;
	uart_baud_loopback dut (.core_clk(core_clk), .sys_rst(sys_rst), .regAddr(regAddr),
		.regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
		.rxPin(rxPin), .txPin(txPin), .ctsPinN(ctsPinN), .dsrPinN(dsrPinN), .cdPinN(cdPinN),
		.riPinN(riPinN), .rtsPinN(rtsPinN), .dtrPinN(dtrPinN), .userOutOneN(userOutOneN),
		.userOutTwoN(userOutTwoN), .intRequest(intRequest), .intPinOut(intPinOut),
		.intPinOeN(intPinOeN));
	uart_line_model line (.core_clk(core_clk), .txPin(txPin), .modemN(modemN),
		.bitClks(bitClks), .rxPin(rxPin), .ctsPinN(ctsPinN), .dsrPinN(dsrPinN),
		.cdPinN(cdPinN), .riPinN(riPinN), .rxDone(rxDone), .rxByte(rxByte));
	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end
	function automatic byte_t lfsr(input byte_t s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	task automatic end_sim();
		// Notes never answered count as misses
		mismatches += serQ.size() + regQ.size();
		$display("compares %0d mismatches %0d", samplesChecked, mismatches);
		if (mismatches == 0 && samplesChecked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic cmpReg(input byte_t e);
		samplesChecked++;
		if (regRdata !== e) begin
			mismatches++;
			$display("[ERR] %0t register exp %h got %h", $time, e, regRdata);
		end
	endtask
	task automatic cmpSer(input byte_t e);
		samplesChecked++;
		if (rxByte !== e) begin
			mismatches++;
			$display("[ERR] %0t line exp %h got %h", $time, e, rxByte);
		end
	endtask
	task automatic wr(input reg_addr_t a, input byte_t d);
		@(posedge core_clk);
		regWr <= 1'b1;
		regAddr <= a;
		regWdata <= d;
		@(posedge core_clk);
		regWr <= 1'b0;
	endtask
	task automatic rd(input reg_addr_t a, input byte_t e, input logic c, output byte_t d);
		@(posedge core_clk);
		regRd <= 1'b1;
		regAddr <= a;
		chk <= c;
		if (c) regQ.push_back(e);
		@(posedge core_clk);
		regRd <= 1'b0;
		chk <= 1'b0;
		@(negedge core_clk);
		d = regRdata;
	endtask
	task automatic waitRx();
		byte_t s;
		s = 8'h00;
		for (int n = 0; n < 3000 && s[0] !== 1'b1; n++) rd(3'h4, 8'h00, 1'b0, s);
	endtask
	task automatic setRate(input int lo, input int hi, input int fr, input int pre);
		wr(3'h0, lo[7:0]);
		wr(3'h1, hi[7:0]);
		wr(3'h3, fr[7:0]);
		wr(3'h2, {pre[0], 7'h00});
		bitClks = (pre ? 4 : 1) * (16 * (hi * 256 + lo) + fr);
	endtask
	// Watcher: results are matched against the oldest note
	always @(posedge core_clk) begin
		chkD <= regRd && chk;
		cyc <= cyc + 1;
		intRequest <= cyc[3] ^ cyc[1];
		if (cyc == 60000) begin
			mismatches++;
			end_sim();
		end
	end
	// Outputs looked at half a cycle after the edge that launches them
	always @(negedge core_clk) begin
		if (chkD) cmpReg(regQ.pop_front());
		if (rxDone) cmpSer(serQ.pop_front());
	end
	initial begin
		byte_t d;
		int cfg [4][4] = '{'{3, 0, 0, 0}, '{1, 0, 8, 0}, '{2, 0, 4, 1}, '{0, 1, 0, 0}};
		repeat (5) @(posedge core_clk);
		sys_rst <= 1'b0;
		rd(3'h0, 8'h01, 1'b1, d);
		rd(3'h1, 8'h00, 1'b1, d);
		rd(3'h2, 8'h00, 1'b1, d);
		wr(3'h3, 8'hf5);
		rd(3'h3, 8'h05, 1'b1, d);
		rd(3'h7, 8'h00, 1'b1, d);
		for (int i = 0; i < 4; i++) begin
			setRate(cfg[i][0], cfg[i][1], cfg[i][2], cfg[i][3]);
			lf = lfsr(lf);
			serQ.push_back(lf);
			wr(3'h6, lf);
			for (int n = 0; n < 50000 && serQ.size() > 0; n++) @(posedge core_clk);
		end
		// Old divisor holds until its tick reloads
		setRate(1, 0, 0, 0);
		repeat (300) @(posedge core_clk);
		lf = lfsr(lf);
		line.send(lf);
		waitRx();
		rd(3'h6, lf, 1'b1, d);
		rd(3'h4, 8'h60, 1'b1, d);
		lf = lfsr(lf);
		modemN <= lf[3:0];
		wr(3'h2, {4'h1, lf[3:0]});
		repeat (6) @(posedge core_clk);
		rd(3'h5, {lf[3], lf[2], lf[0], lf[1], 4'h0}, 1'b1, d);
		lf = lfsr(lf);
		wr(3'h6, lf);
		waitRx();
		rd(3'h6, lf, 1'b1, d);
		wr(3'h2, {4'h0, lf[3:0]});
		repeat (4) @(posedge core_clk);
		rd(3'h5, {~modemN, 4'h0}, 1'b1, d);
		repeat (4) @(posedge core_clk);
		end_sim();
	end
endmodule // uart_baud_loopback_bench
`default_nettype wire
